// ### dv/tx_enable_mute_and_cal_clock_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tx_enable_mute_and_cal_clock_cfg_tb;
	import tx_mute_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, g0, g1, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] d0 = 16'h1000;
	logic [15:0] d1 = 16'h2000;
	logic [15:0] q0, q1, e0, e1;
	logic [3:0]  cdiv;
	logic [1:0]  want;
	int          fails, n_tests;
	int          cyc = 0;
	// ----------------------------------------
	// Harness
	// ----------------------------------------
	tx_gate_driver drv (.pclk(pclk), .presetn(presetn), .want(want),
		.first_dac_tx_gate_pin(g0), .second_dac_tx_gate_pin(g1));
	tx_enable_mute_and_cal_clock_cfg uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.first_dac_tx_gate_pin(g0), .second_dac_tx_gate_pin(g1),
		.first_dac_data_in(d0), .second_dac_data_in(d1),
		.first_dac_data_out(q0), .second_dac_data_out(q1), .cal_clk_div(cdiv));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Samples change every cycle so a stuck output shows up
	always @(posedge pclk) begin
		d0 <= d0 + 16'h0001;
		d1 <= d1 + 16'h0101;
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fails = fails + 1;
			finish_test();
		end
	end
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{want, fails, n_tests} = {2'b11, 64'h0};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, MUTE_SEL_ADDR, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, CAL_DIV_ADDR, 32'h0);
		check(rd, {24'h000000, CAL_DIV_RESET});
		check({28'h0, cdiv}, 32'h00000008);
		apb(1'b1, CAL_DIV_ADDR, 32'hFFFF_FF2A);
		apb(1'b0, CAL_DIV_ADDR, 32'h0);
		check(rd, 32'h0000002A);
		check({28'h0, cdiv}, {28'h0, CAL_DIV_OPTIMIZED});
		apb(1'b0, 12'h004, 32'h0);
		check(rd, 32'h0);
		check({31'h0, err}, 32'h1);
		// An unmapped write must be flagged and leave the divider alone
		apb(1'b1, 12'h004, 32'h000000FF);
		check({31'h0, err}, 32'h1);
		apb(1'b0, CAL_DIV_ADDR, 32'h0);
		check(rd, 32'h0000002A);
		$display("test registers done");
		// Every select and pin mix, reserved bits set to prove they do not gate
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, MUTE_SEL_ADDR, {24'h0, 2'b11, i[3:2], 4'hF});
			want <= i[1:0];
			repeat (5) @(posedge pclk);
			@(negedge pclk);
			e0 = (i[2] && !i[0]) ? 16'h0 : d0 - 16'h0001;
			e1 = (i[3] && !i[1]) ? 16'h0 : d1 - 16'h0101;
			check({16'h0, q0}, {16'h0, e0});
			check({16'h0, q1}, {16'h0, e1});
			@(posedge pclk);
		end
		apb(1'b0, MUTE_SEL_ADDR, 32'h0);
		check(rd, 32'h000000FF);
		$display("test mute paths done");
		finish_test();
	end
endmodule
`default_nettype wire

// ### dv/tx_gate_driver.sv
`timescale 1ns/1ps
`default_nettype none
module tx_gate_driver (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] want,
	output logic            first_dac_tx_gate_pin,
	output logic            second_dac_tx_gate_pin
);
	// ----------------------------------------
	// Controller pins, launched after the edge
	// ----------------------------------------
	// Pins rest high so nothing mutes before software asks for it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_dac_tx_gate_pin  <= 1'b1;
			second_dac_tx_gate_pin <= 1'b1;
		end else begin
			first_dac_tx_gate_pin  <= want[0];
			second_dac_tx_gate_pin <= want[1];
		end
	end
endmodule
`default_nettype wire

// ### shared/tx_mute_pkg.sv
`default_nettype none
package tx_mute_pkg;
	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam int             ADDR_W            = 12;
	localparam logic [11:0]    MUTE_SEL_IDX      = 12'h03F;
	localparam logic [11:0]    CAL_DIV_IDX       = 12'h050;
	localparam logic [11:0]    MUTE_SEL_ADDR     = {MUTE_SEL_IDX[9:0], 2'b00};
	localparam logic [11:0]    CAL_DIV_ADDR      = {CAL_DIV_IDX[9:0], 2'b00};

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int             REG_W             = 8;
	localparam int             FIRST_MUTE_BIT    = 4;
	localparam int             SECOND_MUTE_BIT   = 5;
	localparam int             CAL_DIV_MSB       = 3;
	localparam int             CAL_DIV_LSB       = 0;
	localparam logic [7:0]     MUTE_SEL_RESET    = 8'h00;
	localparam logic [7:0]     CAL_DIV_RESET     = 8'h28;
	localparam logic [3:0]     CAL_DIV_OPTIMIZED = 4'hA;

	// ------------------------------------------------------------
	// Timing counts
	// ------------------------------------------------------------
	localparam int             SYNC_STAGES       = 2;
	localparam int             PIN_TO_OUT_CYCLES = 3;
	localparam int             DATA_TO_OUT_CYCLES = 1;
endpackage
`default_nettype wire

// ### src/tx_enable_mute_and_cal_clock_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module tx_enable_mute_and_cal_clock_cfg #(
	parameter int DATA_W = 16
) (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [tx_mute_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire logic                            first_dac_tx_gate_pin,
	input  wire logic                            second_dac_tx_gate_pin,
	input  wire logic [DATA_W-1:0]               first_dac_data_in,
	input  wire logic [DATA_W-1:0]               second_dac_data_in,
	output logic      [DATA_W-1:0]               first_dac_data_out,
	output logic      [DATA_W-1:0]               second_dac_data_out,
	output logic      [3:0]                      cal_clk_div
);
	import tx_mute_pkg::*;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	logic [REG_W-1:0]   mute_sel;
	logic [REG_W-1:0]   cal_div_reg;
	logic [31:0]        next_prdata;
	wire                hit_mute    = (paddr == MUTE_SEL_ADDR);
	wire                hit_cal     = (paddr == CAL_DIV_ADDR);
	wire                hit_any     = hit_mute | hit_cal;
	wire                setup_phase = psel & ~penable;
	wire                access      = psel & penable;
	wire                wr_mute     = access & pwrite & hit_mute;
	wire                wr_cal      = access & pwrite & hit_cal;

	// Zero wait states: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign pslverr = access & ~hit_any;

	// Read data is latched in the setup cycle so prdata comes from a flop
	always_comb begin
		if (hit_mute) begin
			next_prdata = {24'h000000, mute_sel};
		end else if (hit_cal) begin
			next_prdata = {24'h000000, cal_div_reg};
		end else begin
			next_prdata = 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup_phase && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Reserved bits are kept read/write, so all eight bits are stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mute_sel <= MUTE_SEL_RESET;
		end else if (wr_mute) begin
			mute_sel <= pwdata[REG_W-1:0];
		end
	end

	// Reset leaves 0x8 in the field; software loads the tuned 0xA itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_div_reg <= CAL_DIV_RESET;
		end else if (wr_cal) begin
			cal_div_reg <= pwdata[REG_W-1:0];
		end
	end

	assign cal_clk_div = cal_div_reg[CAL_DIV_MSB:CAL_DIV_LSB];

	// ------------------------------------------------------------
	// Per-DAC gate synchroniser and mute
	// ------------------------------------------------------------
	wire  [1:0]         gate_pin = {second_dac_tx_gate_pin, first_dac_tx_gate_pin};
	wire  [1:0]         mute_en  = {mute_sel[SECOND_MUTE_BIT], mute_sel[FIRST_MUTE_BIT]};
	logic [DATA_W-1:0]  dac_in  [2];
	logic [DATA_W-1:0]  dac_out [2];
	logic [1:0]         gate_meta;
	logic [1:0]         gate_sync;

	assign dac_in[0]           = first_dac_data_in;
	assign dac_in[1]           = second_dac_data_in;
	assign first_dac_data_out  = dac_out[0];
	assign second_dac_data_out = dac_out[1];

	for (genvar ch = 0; ch < 2; ch++) begin : g_dac
		// Reset to high so a path is never muted before the pin is seen
		wire                muted   = mute_en[ch] & ~gate_sync[ch];
		wire [DATA_W-1:0]   next_out = muted ? '0 : dac_in[ch];

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				gate_meta[ch] <= 1'b1;
				gate_sync[ch] <= 1'b1;
			end else begin
				gate_meta[ch] <= gate_pin[ch];
				gate_sync[ch] <= gate_meta[ch];
			end
		end

		// Mute applies on the next sample; no ramp, the zero is abrupt
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				dac_out[ch] <= '0;
			end else begin
				dac_out[ch] <= next_out;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic [1:0] live_cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			live_cnt <= 2'h0;
		end else if (live_cnt != 2'h3) begin
			live_cnt <= live_cnt + 2'h1;
		end
	end

	wire live = (live_cnt == 2'h3);

	// Set once software has written a register, so reset values are checked until then
	logic cal_written;
	logic mute_written;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_written <= 1'b0;
		end else if (wr_cal) begin
			cal_written <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mute_written <= 1'b0;
		end else if (wr_mute) begin
			mute_written <= 1'b1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------
	// Mute path assertions
	// ------------------------------------------------------------
	second_pass_a: assert property (
		live && $past(!mute_sel[SECOND_MUTE_BIT])
		|-> second_dac_data_out == $past(second_dac_data_in))
		else $error("second path altered while its mute select is clear");

	second_zero_a: assert property (
		live && $past(mute_sel[SECOND_MUTE_BIT]) && !$past(second_dac_tx_gate_pin, 3)
		|-> second_dac_data_out == '0)
		else $error("second path not zeroed with gate pin low");

	second_run_a: assert property (
		live && $past(mute_sel[SECOND_MUTE_BIT]) && $past(second_dac_tx_gate_pin, 3)
		|-> second_dac_data_out == $past(second_dac_data_in))
		else $error("second path muted with gate pin high");

	first_pass_a: assert property (
		live && $past(!mute_sel[FIRST_MUTE_BIT])
		|-> first_dac_data_out == $past(first_dac_data_in))
		else $error("first path altered while its mute select is clear");

	first_zero_a: assert property (
		live && $past(mute_sel[FIRST_MUTE_BIT]) && !$past(first_dac_tx_gate_pin, 3)
		|-> first_dac_data_out == '0)
		else $error("first path not zeroed with gate pin low");

	first_run_a: assert property (
		live && $past(mute_sel[FIRST_MUTE_BIT]) && $past(first_dac_tx_gate_pin, 3)
		|-> first_dac_data_out == $past(first_dac_data_in))
		else $error("first path muted with gate pin high");

	gate_sync_a: assert property (
		live |-> gate_sync == $past(gate_pin, 2))
		else $error("gate synchroniser latency is not two cycles");

	// Pin to output is two synchroniser stages plus the output flop
	first_fall_a: assert property (
		live && mute_en[0] && $fell(first_dac_tx_gate_pin)
		##1 mute_en[0] [*2]
		|=> first_dac_data_out == '0)
		else $error("first path not zeroed three cycles after its gate pin fell");

	first_rise_a: assert property (
		live && mute_en[0] && $rose(first_dac_tx_gate_pin)
		##1 mute_en[0] [*2]
		|=> first_dac_data_out == $past(first_dac_data_in))
		else $error("first path not running three cycles after its gate pin rose");

	second_fall_a: assert property (
		live && mute_en[1] && $fell(second_dac_tx_gate_pin)
		##1 mute_en[1] [*2]
		|=> second_dac_data_out == '0)
		else $error("second path not zeroed three cycles after its gate pin fell");

	second_rise_a: assert property (
		live && mute_en[1] && $rose(second_dac_tx_gate_pin)
		##1 mute_en[1] [*2]
		|=> second_dac_data_out == $past(second_dac_data_in))
		else $error("second path not running three cycles after its gate pin rose");

	// ------------------------------------------------------------
	// Register assertions
	// ------------------------------------------------------------
	cal_write_a: assert property (
		wr_cal |=> cal_clk_div == $past(pwdata[CAL_DIV_MSB:CAL_DIV_LSB]))
		else $error("calibration divider write not stored");

	mute_write_a: assert property (
		wr_mute |=> mute_sel == $past(pwdata[REG_W-1:0]))
		else $error("mute select write not stored");

	mute_hold_a: assert property (
		!wr_mute |=> $stable(mute_sel))
		else $error("mute select changed without a write");

	// Hardware must never load the tuned divider by itself
	cal_hold_a: assert property (
		!wr_cal |=> $stable(cal_div_reg))
		else $error("calibration divider changed without a write");

	cal_reset_a: assert property (
		!cal_written |-> cal_clk_div == CAL_DIV_RESET[CAL_DIV_MSB:CAL_DIV_LSB])
		else $error("calibration divider left its reset value unwritten");

	mute_reset_a: assert property (
		!mute_written |-> mute_sel == MUTE_SEL_RESET)
		else $error("mute select left its reset value unwritten");

	read_mute_a: assert property (
		setup_phase && !pwrite && hit_mute |=> prdata == {24'h000000, $past(mute_sel)})
		else $error("mute select read data wrong");

	read_cal_a: assert property (
		setup_phase && !pwrite && hit_cal |=> prdata == {24'h000000, $past(cal_div_reg)})
		else $error("calibration divider read data wrong");

	// ------------------------------------------------------------
	// Bus assertions
	// ------------------------------------------------------------
	bad_addr_a: assert property (
		access && !hit_any |-> pslverr && pready)
		else $error("unmapped access not flagged");

	slverr_only_a: assert property (
		!(access && !hit_any) |-> !pslverr)
		else $error("error flagged outside an unmapped access");

	read_unmapped_a: assert property (
		setup_phase && !pwrite && !hit_any |=> prdata == 32'h00000000)
		else $error("unmapped read returned nonzero data");

	// Read data must stand through the access phase, so only a read setup may move it
	prdata_hold_a: assert property (
		!(setup_phase && !pwrite) |=> $stable(prdata))
		else $error("read data moved outside a read setup");

	unmapped_write_a: assert property (
		access && pwrite && !hit_any |=> $stable(mute_sel) && $stable(cal_div_reg))
		else $error("unmapped write altered a register");

	read_no_effect_a: assert property (
		access && !pwrite |=> $stable(mute_sel) && $stable(cal_div_reg))
		else $error("read altered a register");

	// ------------------------------------------------------------
	// Cover points
	// ------------------------------------------------------------
	first_mute_c:   cover property (live && mute_en[0] && !gate_sync[0]);
	second_mute_c:  cover property (live && mute_en[1] && !gate_sync[1] && gate_sync[0]);
	cal_tuned_c:    cover property (wr_cal ##1 cal_clk_div == CAL_DIV_OPTIMIZED);
	unmapped_c:     cover property (access && !hit_any);
	first_unmute_c: cover property (live && mute_en[0] && $rose(gate_sync[0]));
endmodule
`default_nettype wire
